// ===== design/rpa_pkg.sv
// Purpose: Shared constants for the phase readback and alarm hold slice
// Assumes: One 250 MHz core clock, APB register access
// Notes:   Register indices map to byte addresses at four times the index
package rpa_pkg;
    // ********************************************************
    // Bus and register map
    // ********************************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 8;

    localparam logic [IDX_W-1:0] IDX_PHASE_LO = 8'h77;
    localparam logic [IDX_W-1:0] IDX_PHASE_HI = 8'h78;
    localparam logic [IDX_W-1:0] IDX_HOLD     = 8'h79;
    localparam logic [IDX_W-1:0] IDX_CTRL     = 8'h80;
    localparam logic [IDX_W-1:0] IDX_ALARM    = 8'h81;
    localparam logic [IDX_W-1:0] IDX_IRQ_STS  = 8'h82;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h83;

    // ********************************************************
    // Fields and reset values
    // ********************************************************
    localparam int              PHASE_W      = 16;
    localparam int              BYTE_W       = 8;
    localparam int              HOLD_W       = 6;
    localparam logic [HOLD_W-1:0] HOLD_RST   = 6'h32;
    localparam int              CTRL_SEL_BIT = 4;
    localparam int              IRQ_W        = 2;
    localparam int              IRQ_RAISE    = 0;
    localparam int              IRQ_EXPIRE   = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST     = 2'h0;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int SEC_NS        = 1_000_000_000;
    localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
    localparam int HOLD_UNIT_S   = 2;
    localparam int EXPIRE_S      = 128;
    localparam int SEC_CNT_W     = 8;
    localparam int AVG_SHIFT     = 4;
endpackage : rpa_pkg

// ===== design/rpa_avg_if.sv
// Purpose: Carrier between the register slice and the phase averager
// Assumes: Single clock domain
// Notes:   Sample strobe is one cycle per measurement
`timescale 1ns/1ps
interface rpa_avg_if;
    logic signed [rpa_pkg::PHASE_W-1:0] smp;
    logic                               smp_valid;
    logic signed [rpa_pkg::PHASE_W-1:0] avg;

    modport src   (output smp, output smp_valid, input avg);
    modport filt  (input smp, input smp_valid, output avg);
endinterface : rpa_avg_if

// ===== design/rpa_phase_avg.sv
// Purpose: Running average of the selected loop phase error
// Assumes: Signed two's complement samples
// Notes:   First-order filter, weight set by shift parameter
`timescale 1ns/1ps
module rpa_phase_avg #(
    parameter int AVG_SHIFT = rpa_pkg::AVG_SHIFT
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    rpa_avg_if.filt   bus
);
    localparam int W = rpa_pkg::PHASE_W;

    logic signed [W-1:0] avg_q;
    logic signed [W-1:0] avg_d;
    logic signed [W:0]   diff;
    logic signed [W:0]   step;

    // ********************************************************
    // Averaging
    // ********************************************************
    always_comb begin
        diff  = {bus.smp[W-1], bus.smp} - {avg_q[W-1], avg_q};
        step  = diff >>> AVG_SHIFT;
        avg_d = avg_q;
        if (bus.smp_valid) begin
            avg_d = avg_q + step[W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avg_q <= '0;
        end else begin
            avg_q <= avg_d;
        end
    end

    assign bus.avg = avg_q;

    avg_steady_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !bus.smp_valid || bus.smp == avg_q |=> avg_q == $past(avg_q))
        else $error("Average moved with nothing to track");
endmodule : rpa_phase_avg

// ===== design/rpa_phase_alarm.sv
// Purpose: Phase readback bytes, alarm hold timer and APB register slice
// Assumes: Loop and lock-state inputs come from logic on core_clk
// Notes:   APB answers in the access cycle that follows setup, no extra wait
//
// Behaviour
// - The upper phase byte reads phase bits 15 to 8, ignores writes and resets to zero.
// - The phase value comes from the primary or secondary tracking loop per a select bit.
// - The phase value is an averaged 16-bit two's complement number.
// - Hold is a six-bit count reset to 0x32; an alarm rises after 2*hold seconds of fault.
// - A raised alarm stays until software clears it or until 128 seconds pass.
// - The lower phase byte reads bits 7 to 0 of the phase value.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module rpa_phase_alarm #(
    parameter int N_IN       = 14,
    parameter int SEC_CYCLES = rpa_pkg::SEC_CYCLES
) (
    input  wire logic                               core_clk,
    input  wire logic                               rst_n,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [rpa_pkg::ADDR_W-1:0]         paddr,
    input  wire logic [rpa_pkg::DATA_W-1:0]         pwdata,
    output logic      [rpa_pkg::DATA_W-1:0]         prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic signed [rpa_pkg::PHASE_W-1:0] primary_tracking_loop_phase,
    input  wire logic                               primary_tracking_loop_valid,
    input  wire logic signed [rpa_pkg::PHASE_W-1:0] secondary_tracking_loop_phase,
    input  wire logic                               secondary_tracking_loop_valid,
    input  wire logic [N_IN-1:0]                    lock_fault,
    output logic      [N_IN-1:0]                    phase_alarm,
    output logic                                    irq
);
    localparam int                   DW    = rpa_pkg::DATA_W;
    localparam int                   CW    = rpa_pkg::SEC_CNT_W;
    localparam logic [31:0]          PRE_TOP = 32'(SEC_CYCLES - 1);
    localparam logic [CW-1:0]        EXP_TOP = CW'(rpa_pkg::EXPIRE_S - 1);

    // ********************************************************
    // APB slave
    // ********************************************************
    logic [rpa_pkg::IDX_W-1:0]  idx;
    logic                       setup;
    logic                       acc;
    logic                       wr;
    logic [DW-1:0]              prdata_q;
    logic [DW-1:0]              prdata_d;
    logic                       pready_q;
    logic                       pready_d;
    logic                       pslverr_q;
    logic                       pslverr_d;
    logic                       hit;

    logic [rpa_pkg::HOLD_W-1:0] hold_q;
    logic [rpa_pkg::HOLD_W-1:0] hold_d;
    logic                       sel_q;
    logic                       sel_d;
    logic [rpa_pkg::IRQ_W-1:0]  sts_q;
    logic [rpa_pkg::IRQ_W-1:0]  sts_d;
    logic [rpa_pkg::IRQ_W-1:0]  mask_q;
    logic [rpa_pkg::IRQ_W-1:0]  mask_d;
    logic                       irq_q;
    logic                       irq_d;
    logic [N_IN-1:0]            alarm_q;
    logic [N_IN-1:0]            alarm_clr;
    logic [N_IN-1:0]            raise_ev;
    logic [N_IN-1:0]            expire_ev;
    logic signed [rpa_pkg::PHASE_W-1:0] avg;

    assign idx   = paddr[rpa_pkg::ADDR_W-1:2];
    assign setup = psel && !penable;
    assign acc   = psel && penable && pready_q;
    assign wr    = acc && pwrite;

    always_comb begin
        prdata_d  = '0;
        hit       = 1'b1;
        if (idx == rpa_pkg::IDX_PHASE_LO) begin
            prdata_d[rpa_pkg::BYTE_W-1:0] = avg[rpa_pkg::BYTE_W-1:0];
        end else if (idx == rpa_pkg::IDX_PHASE_HI) begin
            prdata_d[rpa_pkg::BYTE_W-1:0] = avg[rpa_pkg::PHASE_W-1:rpa_pkg::BYTE_W];
        end else if (idx == rpa_pkg::IDX_HOLD) begin
            prdata_d[rpa_pkg::HOLD_W-1:0] = hold_q;
        end else if (idx == rpa_pkg::IDX_CTRL) begin
            prdata_d[rpa_pkg::CTRL_SEL_BIT] = sel_q;
        end else if (idx == rpa_pkg::IDX_ALARM) begin
            prdata_d[N_IN-1:0] = alarm_q;
        end else if (idx == rpa_pkg::IDX_IRQ_STS) begin
            prdata_d[rpa_pkg::IRQ_W-1:0] = sts_q;
        end else if (idx == rpa_pkg::IDX_IRQ_MASK) begin
            prdata_d[rpa_pkg::IRQ_W-1:0] = mask_q;
        end else begin
            hit = 1'b0;
        end
        // Data and status sampled in setup, shown in access
        pready_d  = setup;
        pslverr_d = setup && !hit;
        if (!setup) begin
            prdata_d = prdata_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ********************************************************
    // Control and interrupt registers
    // ********************************************************
    always_comb begin
        hold_d    = hold_q;
        sel_d     = sel_q;
        mask_d    = mask_q;
        sts_d     = sts_q;
        alarm_clr = '0;
        // Upper and lower phase bytes have no write path
        if (wr && idx == rpa_pkg::IDX_HOLD) begin
            hold_d = pwdata[rpa_pkg::HOLD_W-1:0];
        end else if (wr && idx == rpa_pkg::IDX_CTRL) begin
            sel_d = pwdata[rpa_pkg::CTRL_SEL_BIT];
        end else if (wr && idx == rpa_pkg::IDX_ALARM) begin
            alarm_clr = pwdata[N_IN-1:0];
        end else if (wr && idx == rpa_pkg::IDX_IRQ_STS) begin
            sts_d = sts_q & ~pwdata[rpa_pkg::IRQ_W-1:0];
        end else if (wr && idx == rpa_pkg::IDX_IRQ_MASK) begin
            mask_d = pwdata[rpa_pkg::IRQ_W-1:0];
        end
        // New events win over a clear in the same cycle
        if (|raise_ev) begin
            sts_d[rpa_pkg::IRQ_RAISE] = 1'b1;
        end
        if (|expire_ev) begin
            sts_d[rpa_pkg::IRQ_EXPIRE] = 1'b1;
        end
        irq_d = |(sts_q & mask_q);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_q <= rpa_pkg::HOLD_RST;
            sel_q  <= 1'b0;
            mask_q <= rpa_pkg::IRQ_RST;
            sts_q  <= rpa_pkg::IRQ_RST;
            irq_q  <= 1'b0;
        end else begin
            hold_q <= hold_d;
            sel_q  <= sel_d;
            mask_q <= mask_d;
            sts_q  <= sts_d;
            irq_q  <= irq_d;
        end
    end

    assign irq = irq_q;

    // ********************************************************
    // Phase source and averaging
    // ********************************************************
    rpa_avg_if avg_bus ();

    always_comb begin
        if (sel_q) begin
            avg_bus.smp       = secondary_tracking_loop_phase;
            avg_bus.smp_valid = secondary_tracking_loop_valid;
        end else begin
            avg_bus.smp       = primary_tracking_loop_phase;
            avg_bus.smp_valid = primary_tracking_loop_valid;
        end
    end

    rpa_phase_avg #(
        .AVG_SHIFT (rpa_pkg::AVG_SHIFT)
    ) u_avg (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .bus      (avg_bus.filt)
    );

    assign avg = avg_bus.avg;

    // ********************************************************
    // One-second timebase
    // ********************************************************
    logic [31:0] pre_q;
    logic [31:0] pre_d;
    logic        tick_q;
    logic        tick_d;

    always_comb begin
        tick_d = (pre_q == PRE_TOP);
        pre_d  = tick_d ? '0 : pre_q + 32'h0000_0001;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
        end
    end

    // ********************************************************
    // Per-input alarm hold and expiry
    // ********************************************************
    logic [CW-1:0] thresh;
    logic [CW-1:0] cnt_q [N_IN];

    // Hold count times two seconds
    assign thresh = CW'(hold_q) * CW'(rpa_pkg::HOLD_UNIT_S);

    for (genvar i = 0; i < N_IN; i++) begin : g_in
        logic [CW-1:0] cnt_d;
        logic          alarm_d;

        always_comb begin
            cnt_d   = cnt_q[i];
            alarm_d = alarm_q[i];
            if (!alarm_q[i]) begin
                if (!lock_fault[i]) begin
                    cnt_d = '0;
                end else if (cnt_q[i] >= thresh) begin
                    alarm_d = 1'b1;
                    cnt_d   = '0;
                end else if (tick_q) begin
                    cnt_d = cnt_q[i] + CW'(1);
                end
            end else if (alarm_clr[i]) begin
                alarm_d = 1'b0;
                cnt_d   = '0;
            end else if (tick_q) begin
                // Input no longer measured, so the alarm ages out instead
                if (cnt_q[i] == EXP_TOP) begin
                    alarm_d = 1'b0;
                    cnt_d   = '0;
                end else begin
                    cnt_d = cnt_q[i] + CW'(1);
                end
            end
        end

        assign raise_ev[i]  = !alarm_q[i] && alarm_d;
        assign expire_ev[i] = alarm_q[i] && !alarm_d && !alarm_clr[i];

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                cnt_q[i]   <= '0;
                alarm_q[i] <= 1'b0;
            end else begin
                cnt_q[i]   <= cnt_d;
                alarm_q[i] <= alarm_d;
            end
        end
    end

    assign phase_alarm = alarm_q;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence s_setup_rd(logic [rpa_pkg::IDX_W-1:0] r);
        setup && !pwrite && idx == r;
    endsequence

    upper_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_setup_rd(rpa_pkg::IDX_PHASE_HI) |=>
            pready && prdata == {24'h00_0000, $past(avg[15:8])})
        else $error("Upper phase byte read wrong");

    upper_ro_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && idx == rpa_pkg::IDX_PHASE_HI |=> $stable(hold_q) && $stable(sel_q))
        else $error("Write to upper phase byte changed state");

    lower_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_setup_rd(rpa_pkg::IDX_PHASE_LO) |=>
            pready && prdata == {24'h00_0000, $past(avg[7:0])})
        else $error("Lower phase byte read wrong");

    src_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sel_q && secondary_tracking_loop_valid |->
            avg_bus.smp_valid && avg_bus.smp == secondary_tracking_loop_phase)
        else $error("Secondary loop not selected");

    hold_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(!rst_n) |-> hold_q == rpa_pkg::HOLD_RST && !irq && phase_alarm == '0)
        else $error("Hold register reset value wrong");

    alarm_raise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(alarm_q[0]) |-> $past(lock_fault[0]) && $past(cnt_q[0]) >= $past(thresh))
        else $error("Alarm raised before hold time");

    alarm_expire_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(alarm_q[0]) |->
            $past(alarm_clr[0]) || ($past(tick_q) && $past(cnt_q[0]) == EXP_TOP))
        else $error("Alarm dropped without clear or expiry");

    sts_set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        raise_ev[0] |=> sts_q[rpa_pkg::IRQ_RAISE] ##1 (irq || !$past(mask_q[rpa_pkg::IRQ_RAISE])))
        else $error("Raise event lost or interrupt wrong");
endmodule : rpa_phase_alarm

// ===== test/tb_phase_readback_alarm_timeout.sv
// Purpose: Self-checking bench for the phase readback and alarm hold slice
// Assumes: APB with zero wait states, shortened one-second tick of SEC cycles
// Notes:   Reference model folds queued samples into an integer average
`timescale 1ns/1ps
module tb_phase_readback_alarm_timeout;
    localparam int NI  = 4;
    localparam int SEC = 20;
    localparam logic [9:0] A_LO   = {rpa_pkg::IDX_PHASE_LO, 2'b00};
    localparam logic [9:0] A_HI   = {rpa_pkg::IDX_PHASE_HI, 2'b00};
    localparam logic [9:0] A_HOLD = {rpa_pkg::IDX_HOLD, 2'b00};
    localparam logic [9:0] A_CTRL = {rpa_pkg::IDX_CTRL, 2'b00};
    localparam logic [9:0] A_ALRM = {rpa_pkg::IDX_ALARM, 2'b00};
    localparam logic [9:0] A_STS  = {rpa_pkg::IDX_IRQ_STS, 2'b00};
    localparam logic [9:0] A_MASK = {rpa_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [9:0] A_BAD  = 10'h3fc;

    logic               core_clk;
    logic               rst_n;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [9:0]         paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic signed [15:0] pri_phase;
    logic               pri_valid;
    logic signed [15:0] sec_phase;
    logic               sec_valid;
    logic [NI-1:0]      lock_fault;
    logic [NI-1:0]      phase_alarm;
    logic               irq;
    int                 err_count;
    int                 samples_checked;
    int                 avg_m;
    int                 q[$];
    logic [31:0]        rd;
    logic [31:0]        r;
    logic               er;
    int                 n;

    rpa_phase_alarm #(.N_IN(NI), .SEC_CYCLES(SEC)) u_dut (
        .core_clk                      (core_clk),
        .rst_n                         (rst_n),
        .psel                          (psel),
        .penable                       (penable),
        .pwrite                        (pwrite),
        .paddr                         (paddr),
        .pwdata                        (pwdata),
        .prdata                        (prdata),
        .pready                        (pready),
        .pslverr                       (pslverr),
        .primary_tracking_loop_phase   (pri_phase),
        .primary_tracking_loop_valid   (pri_valid),
        .secondary_tracking_loop_phase (sec_phase),
        .secondary_tracking_loop_valid (sec_valid),
        .lock_fault                    (lock_fault),
        .phase_alarm                   (phase_alarm),
        .irq                           (irq)
    );

    // ********************************************************
    // Clock, verdict and watchdog
    // ********************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic close_out();
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        close_out();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // ********************************************************
    // Bus and sample drivers
    // ********************************************************
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Unselected loop strobes at the same edge with a different value
    task automatic smp(input int sel);
        int v;
        int o;
        v = int'($urandom_range(2000)) - 1000;
        o = int'($urandom_range(2000)) - 1000;
        @(posedge core_clk);
        pri_phase <= 16'(sel ? o : v);
        sec_phase <= 16'(sel ? v : o);
        pri_valid <= 1'b1;
        sec_valid <= 1'b1;
        @(posedge core_clk);
        pri_valid <= 1'b0;
        sec_valid <= 1'b0;
        q.push_back(v);
    endtask : smp

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        rst_n           = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = '0;
        pwdata          = '0;
        pri_phase       = '0;
        sec_phase       = '0;
        pri_valid       = 1'b0;
        sec_valid       = 1'b0;
        lock_fault      = '0;
        err_count       = 0;
        samples_checked = 0;
        avg_m           = 0;
        void'($urandom(32'h011749a5));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(0, A_HI, 0);
        check("hi_reset", rd, 32'h0000_0000);
        apb(0, A_LO, 0);
        check("lo_reset", rd, 32'h0000_0000);
        apb(0, A_HOLD, 0);
        check("hold_reset", rd, 32'h0000_0032);
        check("alarm_reset", 32'(phase_alarm), 32'h0000_0000);
        r = $urandom;
        apb(1, A_HI, r);
        apb(0, A_HI, 0);
        check("hi_ro", rd, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            r = $urandom;
            apb(1, A_HOLD, r);
            apb(0, A_HOLD, 0);
            check("hold_rw", rd, r & 32'h0000_003f);
        end
        for (int s = 0; s < 2; s++) begin
            apb(1, A_CTRL, 32'(s) << rpa_pkg::CTRL_SEL_BIT);
            apb(0, A_CTRL, 0);
            check("ctrl_rw", rd, 32'(s) << rpa_pkg::CTRL_SEL_BIT);
            repeat (12) smp(s);
            while (q.size() > 0) begin
                avg_m = avg_m + ((q.pop_front() - avg_m) >>> 4);
            end
            // Lower byte first, upper byte right after
            apb(0, A_LO, 0);
            check("phase_lo", rd, 32'(avg_m & 255));
            apb(0, A_HI, 0);
            check("phase_hi", rd, 32'((avg_m >> 8) & 255));
        end
        r = $urandom;
        apb(1, A_BAD, r);
        check("bad_err_wr", 32'(er), 32'h0000_0001);
        apb(0, A_BAD, 0);
        check("bad_err_rd", 32'(er), 32'h0000_0001);
        check("bad_data", rd, 32'h0000_0000);
        // Raise after hold*2 ticks; free tick makes the first one partial
        apb(1, A_HOLD, 32'h0000_0002);
        @(posedge core_clk);
        lock_fault <= 4'b0001;
        n = 0;
        while (phase_alarm[0] !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        check("raise_time", 32'(n >= 3 * SEC && n <= 4 * SEC + 3), 32'h0000_0001);
        lock_fault <= 4'b0000;
        repeat (2) @(posedge core_clk);
        check("irq_masked", 32'(irq), 32'h0000_0000);
        apb(1, A_MASK, 32'h0000_0001);
        apb(0, A_MASK, 0);
        check("mask_rw", rd, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check("irq_on", 32'(irq), 32'h0000_0001);
        apb(0, A_STS, 0);
        check("sts_raise", rd, 32'h0000_0001);
        check("alarm_held", 32'(phase_alarm), 32'h0000_0001);
        apb(1, A_ALRM, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check("alarm_sw_clr", 32'(phase_alarm), 32'h0000_0000);
        apb(1, A_STS, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check("irq_clr", 32'(irq), 32'h0000_0000);
        // Zero hold raises at once; expiry after 128 ticks
        apb(1, A_HOLD, 32'h0000_0000);
        apb(1, A_MASK, 32'h0000_0003);
        @(posedge core_clk);
        lock_fault <= 4'b0010;
        n = 0;
        while (phase_alarm[1] !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            n++;
        end
        check("raise_zero", 32'(n <= 3), 32'h0000_0001);
        lock_fault <= 4'b0000;
        n = 0;
        while (phase_alarm[1] === 1'b1 && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        check("expire_time", 32'(n >= 127 * SEC - 2 && n <= 128 * SEC + 3), 32'h0000_0001);
        apb(0, A_STS, 0);
        check("sts_expire", rd, 32'h0000_0003);
        repeat (2) @(posedge core_clk);
        check("irq_expire", 32'(irq), 32'h0000_0001);
        // Mid-run reset with an alarm up and a nonzero average
        lock_fault <= 4'b0100;
        repeat (3) @(posedge core_clk);
        check("alarm_pre_rst", 32'(phase_alarm), 32'h0000_0004);
        rst_n      <= 1'b0;
        lock_fault <= 4'b0000;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        avg_m = 0;
        apb(0, A_HOLD, 0);
        check("hold_rst2", rd, 32'h0000_0032);
        check("alarm_rst2", 32'(phase_alarm), 32'h0000_0000);
        check("irq_rst2", 32'(irq), 32'h0000_0000);
        apb(0, A_STS, 0);
        check("sts_rst2", rd, 32'h0000_0000);
        apb(0, A_LO, 0);
        check("lo_rst2", rd, 32'(avg_m & 255));
        apb(0, A_HI, 0);
        check("hi_rst2", rd, 32'((avg_m >> 8) & 255));
        close_out();
    end
endmodule : tb_phase_readback_alarm_timeout
